// >>> sor_ext_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sor_ext_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clockOutEnableStrapPin,
  input wire logic [sor_pkg::MGMT_ADDR_W-1:0] mgmtAddressStrapPin,
  input wire logic nandTreeStrapPin,
  input wire logic gmiiMiiStrapPin,
  input wire logic [sor_pkg::EXT_ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [sor_pkg::DATA_W-1:0] regWrData,
  input wire logic regRdEn,
  output logic [sor_pkg::DATA_W-1:0] regRdData,
  input wire logic [sor_pkg::DATA_W-1:0] basicControlWord,
  output logic ioTristateEn,
  output logic nandTreeMode,
  output logic gmiiMiiMode,
  output logic regulatorCtrlOff,
  output logic lowFreqOscEn,
  output logic clockOutEnable,
  output logic [sor_pkg::MGMT_ADDR_W-1:0] mgmtAddress
);
  import sor_pkg::*;

  sor_strap_if strapIf ();

  sor_strap_capture u_capture (
    .ref_clk(ref_clk),
    .rst(rst),
    .clockOutEnableStrapPin(clockOutEnableStrapPin),
    .mgmtAddressStrapPin(mgmtAddressStrapPin),
    .nandTreeStrapPin(nandTreeStrapPin),
    .gmiiMiiStrapPin(gmiiMiiStrapPin),
    .strapOut(strapIf.producer)
  );

  sor_reg_state_t r_q;
  sor_reg_state_t r_d;
  logic swPowerDown;

  function automatic logic [DATA_W-1:0] readMux(
    input logic [EXT_ADDR_W-1:0] addr,
    input sor_reg_state_t r,
    input logic clkEn,
    input logic [MGMT_ADDR_W-1:0] mAddr,
    input logic nandSt,
    input logic gmii
  );
    logic [DATA_W-1:0] v;
    v = '0;
    if (addr == OFF_STRAP_STATUS) begin
      v[BIT_CLK_OUT_EN] = clkEn;
      v[BIT_MGMT_ADDR_LO +: MGMT_ADDR_W] = mAddr;
    end else if (addr == OFF_MODE_OVERRIDE) begin
      v = r.override;
    end else if (addr == OFF_MODE_STATUS) begin
      v[BIT_NAND_TREE] = nandSt;
      v[BIT_GMII_MII] = gmii;
    end else if (addr == OFF_ANALOG_TEST) begin
      v = r.analog;
    end
    return v;
  endfunction : readMux

  always_comb begin
    r_d = r_q;
    // only the two RW registers accept writes; status and unmapped drop them
    if (regWrEn) begin
      if (regAddr == OFF_MODE_OVERRIDE) begin
        r_d.override = regWrData;
      end else if (regAddr == OFF_ANALOG_TEST) begin
        r_d.analog = regWrData;
      end
    end
    if (regRdEn) begin
      r_d.rdData = readMux(regAddr, r_q, strapIf.clkOutEn, strapIf.mgmtAddr,
        strapIf.nandStrap, strapIf.gmiiStrap);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_q.override <= RST_MODE_OVERRIDE;
      r_q.analog <= RST_ANALOG_TEST;
      r_q.rdData <= RST_READ_DATA;
    end else begin
      r_q <= r_d;
    end
  end

  assign swPowerDown = basicControlWord[BIT_SW_POWER_DOWN];
  assign ioTristateEn = r_q.override[BIT_TRISTATE_IO] & swPowerDown;
  assign nandTreeMode = r_q.override[BIT_NAND_TREE] | strapIf.nandStrap;
  assign gmiiMiiMode = r_q.override[BIT_GMII_MII] | strapIf.gmiiStrap;
  assign regulatorCtrlOff = r_q.analog[BIT_REGULATOR_OFF];
  assign lowFreqOscEn = r_q.analog[BIT_LOW_FREQ_OSC];
  assign clockOutEnable = strapIf.clkOutEn;
  assign mgmtAddress = strapIf.mgmtAddr;
  assign regRdData = r_q.rdData;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  chk_clkout_read: assert property (
    regRdEn && regAddr == OFF_STRAP_STATUS |=>
      regRdData[BIT_CLK_OUT_EN] == $past(strapIf.clkOutEn))
    else $error("strap status bit 5 differs from clock-output strap");

  chk_mgmt_addr_read: assert property (
    regRdEn && regAddr == OFF_STRAP_STATUS |=>
      regRdData[MGMT_ADDR_W-1:0] == $past(strapIf.mgmtAddr)
      && regRdData[DATA_W-1:BIT_CLK_OUT_EN+1] == '0)
    else $error("strap status address field wrong");

  chk_tristate_set: assert property (
    regWrEn && regAddr == OFF_MODE_OVERRIDE && regWrData[BIT_TRISTATE_IO]
      ##1 swPowerDown |-> ioTristateEn)
    else $error("I/Os not tri-stated in power down with bit 7 set");

  chk_tristate_pd_only: assert property (
    !basicControlWord[BIT_SW_POWER_DOWN] |-> !ioTristateEn)
    else $error("I/Os tri-stated outside software power down");

  chk_nand_override: assert property (
    regWrEn && regAddr == OFF_MODE_OVERRIDE && regWrData[BIT_NAND_TREE]
      |=> nandTreeMode)
    else $error("NAND tree override did not take effect");

  chk_gmii_override: assert property (
    regWrEn && regAddr == OFF_MODE_OVERRIDE && regWrData[BIT_GMII_MII]
      |=> gmiiMiiMode)
    else $error("GMII / MII override did not take effect");

  chk_mode_status_read: assert property (
    regRdEn && regAddr == OFF_MODE_STATUS |=>
      regRdData[BIT_NAND_TREE] == $past(strapIf.nandStrap)
      && regRdData[BIT_GMII_MII] == $past(strapIf.gmiiStrap))
    else $error("mode strap status wrong");

  chk_status_write_drop: assert property (
    regWrEn && (regAddr == OFF_STRAP_STATUS || regAddr == OFF_MODE_STATUS)
      |=> $stable(r_q.override) && $stable(r_q.analog))
    else $error("write to status register changed state");

  chk_analog_write: assert property (
    regWrEn && regAddr == OFF_ANALOG_TEST |=>
      regulatorCtrlOff == $past(regWrData[BIT_REGULATOR_OFF])
      && lowFreqOscEn == $past(regWrData[BIT_LOW_FREQ_OSC]))
    else $error("analog test controls do not follow write");

  chk_reset_values: assert property (
    $past(rst) |-> !regulatorCtrlOff && !lowFreqOscEn && !ioTristateEn
      && r_q.override == RST_MODE_OVERRIDE)
    else $error("control bits not zero after reset");

endmodule : sor_ext_regs
`default_nettype wire

// >>> sor_pkg.sv
package sor_pkg;

  // extended register addresses
  localparam int EXT_ADDR_W = 9;
  localparam logic [EXT_ADDR_W-1:0] OFF_STRAP_STATUS = 9'h101;
  localparam logic [EXT_ADDR_W-1:0] OFF_MODE_OVERRIDE = 9'h102;
  localparam logic [EXT_ADDR_W-1:0] OFF_MODE_STATUS = 9'h103;
  localparam logic [EXT_ADDR_W-1:0] OFF_ANALOG_TEST = 9'h107;

  localparam int DATA_W = 16;
  localparam int MGMT_ADDR_W = 5;

  // field positions
  localparam int BIT_CLK_OUT_EN = 5;
  localparam int BIT_MGMT_ADDR_LO = 0;
  localparam int BIT_TRISTATE_IO = 7;
  localparam int BIT_NAND_TREE = 4;
  localparam int BIT_GMII_MII = 1;
  localparam int BIT_REGULATOR_OFF = 15;
  localparam int BIT_LOW_FREQ_OSC = 8;
  localparam int BIT_SW_POWER_DOWN = 11;

  // reset values
  localparam logic [DATA_W-1:0] RST_MODE_OVERRIDE = 16'h0000;
  localparam logic [DATA_W-1:0] RST_ANALOG_TEST = 16'h0000;
  localparam logic [DATA_W-1:0] RST_READ_DATA = 16'h0000;

  // strap vector: {clkOutEn, mgmtAddr[4:0], nandTree, gmiiMii}
  localparam int STRAP_W = 8;
  // cycles after reset release before the synchronised straps are trusted
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

  typedef struct packed {
    logic [STRAP_W-1:0] sync1;
    logic [STRAP_W-1:0] sync2;
    logic [1:0] settle;
    logic valid;
    logic [STRAP_W-1:0] held;
  } sor_cap_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] override;
    logic [DATA_W-1:0] analog;
    logic [DATA_W-1:0] rdData;
  } sor_reg_state_t;

endpackage : sor_pkg

// >>> sor_strap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sor_strap_if;
  logic capValid;
  logic clkOutEn;
  logic [sor_pkg::MGMT_ADDR_W-1:0] mgmtAddr;
  logic nandStrap;
  logic gmiiStrap;
  modport producer (output capValid, clkOutEn, mgmtAddr, nandStrap,
    gmiiStrap);
  modport consumer (input capValid, clkOutEn, mgmtAddr, nandStrap,
    gmiiStrap);
endinterface : sor_strap_if
`default_nettype wire

// >>> sor_strap_capture.sv
`timescale 1ns/1ps
`default_nettype none
module sor_strap_capture (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clockOutEnableStrapPin,
  input wire logic [sor_pkg::MGMT_ADDR_W-1:0] mgmtAddressStrapPin,
  input wire logic nandTreeStrapPin,
  input wire logic gmiiMiiStrapPin,
  sor_strap_if.producer strapOut
);
  import sor_pkg::*;

  sor_cap_state_t s_q;
  sor_cap_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = {clockOutEnableStrapPin, mgmtAddressStrapPin,
      nandTreeStrapPin, gmiiMiiStrapPin};
    s_d.sync2 = s_q.sync1;
    if (!s_q.valid) begin
      if (s_q.settle == STRAP_SETTLE_CYCLES) begin
        // latch once after release, then hold until next reset
        s_d.valid = 1'b1;
        s_d.held = s_q.sync2;
      end else begin
        s_d.settle = s_q.settle + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign strapOut.capValid = s_q.valid;
  assign strapOut.clkOutEn = s_q.held[STRAP_W-1];
  assign strapOut.mgmtAddr = s_q.held[STRAP_W-2:2];
  assign strapOut.nandStrap = s_q.held[1];
  assign strapOut.gmiiStrap = s_q.held[0];

  chk_capture_timing: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> ##2 !s_q.valid ##1 s_q.valid)
    else $error("strap capture not valid three cycles after reset");

  chk_capture_held: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.valid |=> s_q.valid && $stable(s_q.held))
    else $error("captured strap values changed after capture");

endmodule : sor_strap_capture
`default_nettype wire

// >>> sor_mgmt_host.sv
`timescale 1ns/1ps
`default_nettype none
module sor_mgmt_host (
  input wire logic ref_clk,
  output logic [sor_pkg::EXT_ADDR_W-1:0] regAddr,
  output logic regWrEn,
  output logic [sor_pkg::DATA_W-1:0] regWrData,
  output logic regRdEn,
  input wire logic [sor_pkg::DATA_W-1:0] regRdData
);
  import sor_pkg::*;
  initial begin
    regAddr = '0;
    regWrEn = 1'h0;
    regWrData = '0;
    regRdEn = 1'h0;
  end
  // idle lines carry the inverse so stale values never look valid
  task automatic wr(input logic [EXT_ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'h1;
    @(posedge ref_clk);
    regWrEn <= 1'h0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask : wr
  task automatic rd(input logic [EXT_ADDR_W-1:0] a,
                    output logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'h1;
    @(posedge ref_clk);
    regRdEn <= 1'h0;
    regAddr <= ~a;
    #1;
    d = regRdData;
  endtask : rd
  // update only the masked bits, keep reserved bits as read
  task automatic rmw(input logic [EXT_ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] v, input logic [DATA_W-1:0] m);
    logic [DATA_W-1:0] cur;
    rd(a, cur);
    wr(a, (cur & ~m) | (v & m));
  endtask : rmw
endmodule : sor_mgmt_host
`default_nettype wire

// >>> strap_override_ext_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module strap_override_ext_regs_test;
  import sor_pkg::*;
  logic ref_clk, rst, clkPin, nandPin, gmiiPin, regWrEn, regRdEn;
  logic [4:0] addrPin, mgmtAddress;
  logic [8:0] regAddr;
  logic [15:0] regWrData, regRdData, basicControlWord, v;
  logic ioTristateEn, nandTreeMode, gmiiMiiMode, regulatorCtrlOff;
  logic lowFreqOscEn, clockOutEnable;
  int n_mismatch = 0;
  int total_checks = 0;
  sor_ext_regs DUT (.ref_clk(ref_clk), .rst(rst),
    .clockOutEnableStrapPin(clkPin), .mgmtAddressStrapPin(addrPin),
    .nandTreeStrapPin(nandPin), .gmiiMiiStrapPin(gmiiPin),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData),
    .basicControlWord(basicControlWord), .ioTristateEn(ioTristateEn),
    .nandTreeMode(nandTreeMode), .gmiiMiiMode(gmiiMiiMode),
    .regulatorCtrlOff(regulatorCtrlOff), .lowFreqOscEn(lowFreqOscEn),
    .clockOutEnable(clockOutEnable), .mgmtAddress(mgmtAddress));
  sor_mgmt_host host (.ref_clk(ref_clk), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData));
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic do_reset(input logic c, input logic [4:0] a,
                          input logic n, input logic g);
    @(posedge ref_clk);
    rst <= 1'h1;
    clkPin <= c;
    addrPin <= a;
    nandPin <= n;
    gmiiPin <= g;
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (4) @(posedge ref_clk);
    // late pin changes must not reach the captured values
    clkPin <= ~c;
    addrPin <= ~a;
    nandPin <= ~n;
    gmiiPin <= ~g;
  endtask : do_reset
  task automatic t_straps(input logic [15:0] st, input logic [15:0] md);
    host.rd(OFF_STRAP_STATUS, v);
    chk("strapStatus", v, st);
    chk("clockOutEnable", 16'(clockOutEnable), 16'(st[5]));
    chk("mgmtAddress", 16'(mgmtAddress), 16'(st[4:0]));
    host.rd(OFF_MODE_STATUS, v);
    chk("modeStatus", v, md);
    chk("gmiiMiiMode", 16'(gmiiMiiMode), 16'(md[1]));
    chk("nandTreeMode", 16'(nandTreeMode), 16'(md[4]));
    host.wr(OFF_STRAP_STATUS, 16'hffff);
    host.wr(OFF_MODE_STATUS, 16'hffff);
    host.rd(OFF_STRAP_STATUS, v);
    chk("strapStatusRo", v, st);
    host.rd(OFF_MODE_STATUS, v);
    chk("modeStatusRo", v, md);
    host.rd(9'h100, v);
    chk("unmapped", v, 16'h0000);
  endtask : t_straps
  task automatic t_override();
    host.rd(OFF_MODE_OVERRIDE, v);
    chk("overrideReset", v, 16'h0000);
    host.rd(OFF_ANALOG_TEST, v);
    chk("analogReset", v, 16'h0000);
    host.rmw(OFF_MODE_OVERRIDE, 16'h0092, 16'h0092);
    @(posedge ref_clk);
    chk("nandForced", 16'(nandTreeMode), 16'h0001);
    chk("gmiiForced", 16'(gmiiMiiMode), 16'h0001);
    chk("noPowerDownIo", 16'(ioTristateEn), 16'h0000);
    basicControlWord <= 16'h0800;
    @(posedge ref_clk);
    #1;
    chk("tristatePd", 16'(ioTristateEn), 16'h0001);
    host.rmw(OFF_MODE_OVERRIDE, 16'h0000, 16'h0080);
    #1;
    chk("tristateOff", 16'(ioTristateEn), 16'h0000);
    host.rd(OFF_MODE_OVERRIDE, v);
    chk("overrideRb", v, 16'h0012);
    basicControlWord <= 16'h0000;
  endtask : t_override
  task automatic t_analog();
    host.wr(OFF_ANALOG_TEST, 16'h8100);
    #1;
    chk("regOff", 16'(regulatorCtrlOff), 16'h0001);
    chk("lowFreq", 16'(lowFreqOscEn), 16'h0001);
    host.rmw(OFF_ANALOG_TEST, 16'h0000, 16'h8000);
    #1;
    chk("regOn", 16'(regulatorCtrlOff), 16'h0000);
    chk("lowFreqKept", 16'(lowFreqOscEn), 16'h0001);
    host.rd(OFF_ANALOG_TEST, v);
    chk("analogRb", v, 16'h0100);
  endtask : t_analog
  // gmii strap is low here, so only the override can raise the mode
  task automatic t_gmii_override();
    host.wr(OFF_MODE_OVERRIDE, 16'h0002);
    #1;
    chk("gmiiForced2", 16'(gmiiMiiMode), 16'h0001);
    chk("nandStrapKept", 16'(nandTreeMode), 16'h0001);
    host.wr(OFF_MODE_OVERRIDE, 16'h0000);
    #1;
    chk("gmiiStrapBack", 16'(gmiiMiiMode), 16'h0000);
  endtask : t_gmii_override
  initial begin
    rst = 1'h1;
    basicControlWord = 16'h0000;
    {clkPin, addrPin, nandPin, gmiiPin} = '0;
    do_reset(1'h1, 5'h15, 1'h0, 1'h1);
    t_straps(16'h0035, 16'h0002);
    t_override();
    t_analog();
    do_reset(1'h0, 5'h0a, 1'h1, 1'h0);
    t_straps(16'h000a, 16'h0010);
    t_gmii_override();
    final_report();
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule : strap_override_ext_regs_test
`default_nettype wire
